// >>> ats_cpu_model.sv
`timescale 1ns/10ps
// Processor model: issues the port instructions and the reference, fill, fault and
// interrupt events that the translator status logic watches.
module ats_cpu_model
(
    input  wire logic               ref_clk_i,
    input  wire logic               read_valid_i,
    input  wire ats_pkg::ats_word_t read_data_i,
    output logic                    load_op_o,
    output ats_pkg::ats_word_t      load_data_o,
    output logic                    read_op_o,
    output logic [3:0]              event_o,
    output logic                    prot_fault_o,
    output logic [2:0]              cause_o,
    output logic                    single_cycle_o
);
    import ats_pkg::*;

    initial
    begin
        load_op_o      = 1'b0;
        load_data_o    = 16'h0000;
        read_op_o      = 1'b0;
        event_o        = 4'h0;
        prot_fault_o   = 1'b0;
        cause_o        = 3'h0;
        single_cycle_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle

    // Released data shows the inverse so a stale word is never mistaken for a fresh one.
    task automatic load_word(input ats_word_t w);
        @(posedge ref_clk_i);
        load_op_o   <= 1'b1;
        load_data_o <= w;
        @(posedge ref_clk_i);
        load_op_o   <= 1'b0;
        load_data_o <= ~w;
    endtask : load_word

    // Event bits: 0 memory reference, 1 indirect reference, 2 table fill, 3 interrupt.
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        event_o[k] <= 1'b1;
        @(posedge ref_clk_i);
        event_o[k] <= 1'b0;
    endtask : pulse

    // Cause bits: 0 port guard, 1 write guard, 2 deferral guard.
    task automatic fault(input logic [2:0] c, input logic sc);
        @(posedge ref_clk_i);
        prot_fault_o   <= 1'b1;
        cause_o        <= c;
        single_cycle_o <= sc;
        @(posedge ref_clk_i);
        prot_fault_o   <= 1'b0;
        cause_o        <= ~c;
        single_cycle_o <= 1'b0;
    endtask : fault

    task automatic read_word(output ats_word_t w, output bit ok);
        ok = 1'b0;
        w  = 16'h0000;
        @(posedge ref_clk_i);
        read_op_o <= 1'b1;
        @(posedge ref_clk_i);
        read_op_o <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (read_valid_i === 1'b1)
            begin
                ok = 1'b1;
                w  = read_data_i;
            end
            else
                @(posedge ref_clk_i);
        end
    endtask : read_word

endmodule : ats_cpu_model

// >>> ats_pkg.sv
package ats_pkg;

    localparam int unsigned ATS_DATA_W = 16;

    typedef logic [ATS_DATA_W-1:0] ats_word_t;
    typedef logic [1:0]            ats_user_table_t;
    typedef logic [2:0]            ats_selector_t;

    typedef enum logic [3:0]
    {
        ATS_USR_OFF      = 4'h1,
        ATS_USR_WAIT_IND = 4'h2,
        ATS_USR_WAIT_MEM = 4'h4,
        ATS_USR_ON       = 4'h8
    } ats_usr_state_t;

    // Word bit positions; the word numbers its bits from the top, so word bit 0 is index 15.
    localparam int unsigned ATS_BIT_MTE_HI = 15;
    localparam int unsigned ATS_BIT_USR    = 14;
    localparam int unsigned ATS_BIT_IOF    = 13;
    localparam int unsigned ATS_BIT_WPF    = 12;
    localparam int unsigned ATS_BIT_IDF    = 11;
    localparam int unsigned ATS_BIT_SC     = 10;
    localparam int unsigned ATS_SEL_HI     = 9;
    localparam int unsigned ATS_SEL_LO     = 7;
    localparam int unsigned ATS_BIT_LEF    = 6;
    localparam int unsigned ATS_BIT_IOP    = 5;
    localparam int unsigned ATS_BIT_WP     = 4;
    localparam int unsigned ATS_BIT_INP    = 3;
    localparam int unsigned ATS_BIT_MTE_LO = 2;
    localparam int unsigned ATS_BIT_DCH    = 1;
    localparam int unsigned ATS_BIT_UI_EN  = 0;

    // User table codes on {word bit 0, word bit 13}.
    localparam ats_user_table_t ATS_TABLE_A = 2'h0;
    localparam ats_user_table_t ATS_TABLE_B = 2'h1;
    localparam ats_user_table_t ATS_TABLE_C = 2'h2;
    localparam ats_user_table_t ATS_TABLE_D = 2'h3;

    // Table selector codes.
    localparam ats_selector_t ATS_SEL_USER_A = 3'h0;
    localparam ats_selector_t ATS_SEL_USER_C = 3'h1;
    localparam ats_selector_t ATS_SEL_USER_B = 3'h2;
    localparam ats_selector_t ATS_SEL_USER_D = 3'h3;
    localparam ats_selector_t ATS_SEL_CHAN_A = 3'h4;
    localparam ats_selector_t ATS_SEL_CHAN_C = 3'h5;
    localparam ats_selector_t ATS_SEL_CHAN_B = 3'h6;
    localparam ats_selector_t ATS_SEL_CHAN_D = 3'h7;

    localparam ats_word_t       ATS_WORD_RST  = 16'h0000;
    localparam ats_user_table_t ATS_TABLE_RST = 2'h0;
    localparam ats_selector_t   ATS_SEL_RST   = 3'h0;

endpackage : ats_pkg

// >>> ats_translator_status.sv
`timescale 1ns/10ps
// Overview of operation
// - Written config applies after next memory reference, except channel translation and table selector, which apply at the load
// - Read returns present state, not pending config
// - Read bits 0,13 give enabled user table
// - Read bit 1 shows user translation active
// - Read bit 2 flags port guard fault
// - Read bit 3 flags write guard fault
// - Read bit 4 flags deferral guard fault
// - Read bit 5 flags fault during single-cycle translate
// - Read bits 6-8 give last filled table
// - Selector codes user A,C,B,D then channel A,C,B,D
// - Read bit 9 shows effective address mode
// - Read bit 10 shows port protection enable
// - Read bit 11 shows write protection enable
// - Read bit 12 shows deferral protection enable
// - Read bit 14 shows channel translation on
// - Read bit 15 shows interrupt taken while mapped
module ats_translator_status
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     translator_load_op_i,
    input  wire ats_pkg::ats_word_t       load_data_i,
    input  wire logic                     translator_read_op_i,
    output logic                          read_valid_o,
    output ats_pkg::ats_word_t            read_data_o,
    input  wire logic                     mem_ref_i,
    input  wire logic                     indirect_ref_i,
    input  wire logic                     table_fill_op_i,
    input  wire logic                     single_cycle_translate_op_i,
    input  wire logic                     prot_fault_i,
    input  wire logic                     port_guard_fault_i,
    input  wire logic                     write_guard_fault_i,
    input  wire logic                     deferral_guard_fault_i,
    input  wire logic                     interrupt_taken_i,
    output logic                          user_translation_on_o,
    output logic                          channel_translation_on_o,
    output ats_pkg::ats_user_table_t      user_table_enable_o,
    output ats_pkg::ats_selector_t        table_selector_o,
    output logic                          effective_address_mode_o,
    output logic                          port_protect_o,
    output logic                          write_protect_o,
    output logic                          deferral_protect_o
);
    import ats_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Field extraction.

    function automatic ats_user_table_t ats_table_of(input ats_word_t w);
        ats_table_of = {w[ATS_BIT_MTE_HI], w[ATS_BIT_MTE_LO]};
    endfunction : ats_table_of

    wire ats_user_table_t wr_table   = ats_table_of(load_data_i);
    wire ats_selector_t   wr_sel     = load_data_i[ATS_SEL_HI:ATS_SEL_LO];
    wire logic            wr_lef     = load_data_i[ATS_BIT_LEF];
    wire logic            wr_iop     = load_data_i[ATS_BIT_IOP];
    wire logic            wr_wp      = load_data_i[ATS_BIT_WP];
    wire logic            wr_inp     = load_data_i[ATS_BIT_INP];
    wire logic            wr_dch     = load_data_i[ATS_BIT_DCH];
    wire logic            wr_usr     = load_data_i[ATS_BIT_UI_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // Pending configuration, held until the next memory reference.

    ats_user_table_t pend_table_q;
    ats_user_table_t pend_table_d;
    logic            pend_lef_q;
    logic            pend_lef_d;
    logic            pend_iop_q;
    logic            pend_iop_d;
    logic            pend_wp_q;
    logic            pend_wp_d;
    logic            pend_inp_q;
    logic            pend_inp_d;
    logic            pend_usr_q;
    logic            pend_usr_d;
    logic            cfg_pend_q;
    logic            cfg_pend_d;

    // A load in the same cycle as a reference waits for the following reference.
    wire logic apply_cfg = cfg_pend_q & mem_ref_i & ~translator_load_op_i;

    assign pend_table_d = translator_load_op_i ? wr_table : pend_table_q;
    assign pend_lef_d   = translator_load_op_i ? wr_lef   : pend_lef_q;
    assign pend_iop_d   = translator_load_op_i ? wr_iop   : pend_iop_q;
    assign pend_wp_d    = translator_load_op_i ? wr_wp    : pend_wp_q;
    assign pend_inp_d   = translator_load_op_i ? wr_inp   : pend_inp_q;
    assign pend_usr_d   = translator_load_op_i ? wr_usr   : pend_usr_q;
    assign cfg_pend_d   = translator_load_op_i | (cfg_pend_q & ~mem_ref_i);

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_table_q <= ATS_TABLE_RST;
            pend_lef_q   <= 1'b0;
            pend_iop_q   <= 1'b0;
            pend_wp_q    <= 1'b0;
            pend_inp_q   <= 1'b0;
            pend_usr_q   <= 1'b0;
            cfg_pend_q   <= 1'b0;
        end
        else
        begin
            pend_table_q <= pend_table_d;
            pend_lef_q   <= pend_lef_d;
            pend_iop_q   <= pend_iop_d;
            pend_wp_q    <= pend_wp_d;
            pend_inp_q   <= pend_inp_d;
            pend_usr_q   <= pend_usr_d;
            cfg_pend_q   <= cfg_pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Present user context and channel translation.

    ats_user_table_t act_table_q;
    ats_user_table_t act_table_d;
    logic            act_lef_q;
    logic            act_lef_d;
    logic            act_iop_q;
    logic            act_iop_d;
    logic            act_wp_q;
    logic            act_wp_d;
    logic            act_inp_q;
    logic            act_inp_d;
    logic            dch_on_q;
    logic            dch_on_d;
    ats_selector_t   fill_sel_q;
    ats_selector_t   fill_sel_d;
    ats_selector_t   last_fill_q;
    ats_selector_t   last_fill_d;

    assign act_table_d = apply_cfg ? pend_table_q : act_table_q;
    assign act_lef_d   = apply_cfg ? pend_lef_q   : act_lef_q;
    assign act_iop_d   = apply_cfg ? pend_iop_q   : act_iop_q;
    assign act_wp_d    = apply_cfg ? pend_wp_q    : act_wp_q;
    assign act_inp_d   = apply_cfg ? pend_inp_q   : act_inp_q;
    assign dch_on_d    = translator_load_op_i ? wr_dch : dch_on_q;
    assign fill_sel_d  = translator_load_op_i ? wr_sel : fill_sel_q;
    assign last_fill_d = table_fill_op_i ? fill_sel_q : last_fill_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            act_table_q <= ATS_TABLE_RST;
            act_lef_q   <= 1'b0;
            act_iop_q   <= 1'b0;
            act_wp_q    <= 1'b0;
            act_inp_q   <= 1'b0;
            dch_on_q    <= 1'b0;
            fill_sel_q  <= ATS_SEL_RST;
            last_fill_q <= ATS_SEL_RST;
        end
        else
        begin
            act_table_q <= act_table_d;
            act_lef_q   <= act_lef_d;
            act_iop_q   <= act_iop_d;
            act_wp_q    <= act_wp_d;
            act_inp_q   <= act_inp_d;
            dch_on_q    <= dch_on_d;
            fill_sel_q  <= fill_sel_d;
            last_fill_q <= last_fill_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // User translation enable sequence: armed by a load, then indirect, then reference.

    ats_usr_state_t usr_state_q;
    ats_usr_state_t usr_state_d;

    always_comb
    begin
        usr_state_d = usr_state_q;
        if (apply_cfg && !pend_usr_q)
        begin
            usr_state_d = ATS_USR_OFF;
        end
        else
        begin
            case (usr_state_q)
                ATS_USR_OFF:
                begin
                    if (translator_load_op_i && wr_usr)
                    begin
                        usr_state_d = ATS_USR_WAIT_IND;
                    end
                end
                ATS_USR_WAIT_IND:
                begin
                    if (indirect_ref_i)
                    begin
                        usr_state_d = ATS_USR_WAIT_MEM;
                    end
                end
                ATS_USR_WAIT_MEM:
                begin
                    if (mem_ref_i)
                    begin
                        usr_state_d = ATS_USR_ON;
                    end
                end
                ATS_USR_ON:
                begin
                    usr_state_d = ATS_USR_ON;
                end
                default:
                begin
                    usr_state_d = ATS_USR_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            usr_state_q <= ATS_USR_OFF;
        end
        else
        begin
            usr_state_q <= usr_state_d;
        end
    end

    wire logic usr_on = (usr_state_q == ATS_USR_ON);

    ////////////////////////////////////////////////////////////////////////////////
    // Fault cause and interrupt context capture.

    logic iof_q;
    logic wpf_q;
    logic idf_q;
    logic sc_q;
    logic ui_q;
    logic iof_d;
    logic wpf_d;
    logic idf_d;
    logic sc_d;
    logic ui_d;

    // Each fault replaces the previous cause, so only the latest one shows.
    assign iof_d = prot_fault_i ? port_guard_fault_i          : iof_q;
    assign wpf_d = prot_fault_i ? write_guard_fault_i         : wpf_q;
    assign idf_d = prot_fault_i ? deferral_guard_fault_i      : idf_q;
    assign sc_d  = prot_fault_i ? single_cycle_translate_op_i : sc_q;
    assign ui_d  = interrupt_taken_i ? usr_on : ui_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            iof_q <= 1'b0;
            wpf_q <= 1'b0;
            idf_q <= 1'b0;
            sc_q  <= 1'b0;
            ui_q  <= 1'b0;
        end
        else
        begin
            iof_q <= iof_d;
            wpf_q <= wpf_d;
            idf_q <= idf_d;
            sc_q  <= sc_d;
            ui_q  <= ui_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read word assembly and read port.

    ats_word_t status_word;
    ats_word_t read_data_q;
    ats_word_t read_data_d;
    logic      read_valid_q;

    always_comb
    begin
        status_word                        = ATS_WORD_RST;
        status_word[ATS_BIT_MTE_HI]        = act_table_q[1];
        status_word[ATS_BIT_MTE_LO]        = act_table_q[0];
        status_word[ATS_BIT_USR]           = usr_on;
        status_word[ATS_BIT_IOF]           = iof_q;
        status_word[ATS_BIT_WPF]           = wpf_q;
        status_word[ATS_BIT_IDF]           = idf_q;
        status_word[ATS_BIT_SC]            = sc_q;
        status_word[ATS_SEL_HI:ATS_SEL_LO] = last_fill_q;
        status_word[ATS_BIT_LEF]           = act_lef_q;
        status_word[ATS_BIT_IOP]           = act_iop_q;
        status_word[ATS_BIT_WP]            = act_wp_q;
        status_word[ATS_BIT_INP]           = act_inp_q;
        status_word[ATS_BIT_DCH]           = dch_on_q;
        status_word[ATS_BIT_UI_EN]         = ui_q;
    end

    assign read_data_d = translator_read_op_i ? status_word : read_data_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            read_data_q  <= ATS_WORD_RST;
            read_valid_q <= 1'b0;
        end
        else
        begin
            read_data_q  <= read_data_d;
            read_valid_q <= translator_read_op_i;
        end
    end

    assign read_data_o              = read_data_q;
    assign read_valid_o             = read_valid_q;
    assign user_translation_on_o    = usr_on;
    assign channel_translation_on_o = dch_on_q;
    assign user_table_enable_o      = act_table_q;
    assign table_selector_o         = fill_sel_q;
    assign effective_address_mode_o = act_lef_q;
    assign port_protect_o           = act_iop_q;
    assign write_protect_o          = act_wp_q;
    assign deferral_protect_o       = act_inp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    cfg_apply_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg_pend_q && mem_ref_i && !translator_load_op_i)
        |=> (act_iop_q == $past(pend_iop_q)) && (act_lef_q == $past(pend_lef_q)) && !cfg_pend_q)
        else $error("Pending configuration not applied at memory reference.");

    cfg_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (translator_load_op_i && !cfg_pend_q) |=> $stable(act_table_q) && $stable(act_wp_q))
        else $error("Configuration took effect before a memory reference.");

    read_state_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        translator_read_op_i |=> read_valid_o
            && (read_data_o[ATS_BIT_USR] == $past(usr_on))
            && (read_data_o[ATS_BIT_WP] == $past(act_wp_q)))
        else $error("Read word does not show present state.");

    read_table_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        translator_read_op_i
        |=> {read_data_o[ATS_BIT_MTE_HI], read_data_o[ATS_BIT_MTE_LO]} == $past(act_table_q))
        else $error("Read table field wrong.");

    fault_cause_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        prot_fault_i |=> (iof_q == $past(port_guard_fault_i))
            && (wpf_q == $past(write_guard_fault_i))
            && (idf_q == $past(deferral_guard_fault_i))
            && (sc_q == $past(single_cycle_translate_op_i)))
        else $error("Fault cause not captured.");

    fill_table_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (translator_load_op_i ##1 !translator_load_op_i
            ##1 (table_fill_op_i && !translator_load_op_i))
        |=> last_fill_q == $past(load_data_i[ATS_SEL_HI:ATS_SEL_LO], 3))
        else $error("Filled table not recorded.");

    chan_on_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        translator_load_op_i |=> channel_translation_on_o == $past(wr_dch))
        else $error("Channel translation did not follow the write.");

    usr_rise_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(user_translation_on_o)
        |-> $past(usr_state_q == ATS_USR_WAIT_MEM) && $past(mem_ref_i))
        else $error("User translation rose without indirect then reference.");

    mapped_irq_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        interrupt_taken_i |=> ui_q == $past(user_translation_on_o))
        else $error("Interrupt context not captured.");

endmodule : ats_translator_status

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ats_pkg::*;

    logic       ref_clk_i;
    logic       rst_n_i;
    logic       ld;
    ats_word_t  ld_data;
    logic       rd;
    logic       rd_valid;
    ats_word_t  rd_data;
    logic [3:0] ev;
    logic       flt;
    logic [2:0] cause;
    logic       sc;
    logic       usr_on;
    logic       dch_on;
    logic       ea_mode;
    logic       port_prot;
    logic       wr_prot;
    logic       def_prot;
    ats_user_table_t ute;
    ats_selector_t   sel;
    int         fails;
    int         n_checks;
    ats_word_t  r;

    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    ats_translator_status ats_translator_status_i
    (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .translator_load_op_i(ld), .load_data_i(ld_data),
        .translator_read_op_i(rd), .read_valid_o(rd_valid), .read_data_o(rd_data),
        .mem_ref_i(ev[0]), .indirect_ref_i(ev[1]), .table_fill_op_i(ev[2]),
        .single_cycle_translate_op_i(sc), .prot_fault_i(flt),
        .port_guard_fault_i(cause[0]), .write_guard_fault_i(cause[1]),
        .deferral_guard_fault_i(cause[2]), .interrupt_taken_i(ev[3]),
        .user_translation_on_o(usr_on), .channel_translation_on_o(dch_on),
        .user_table_enable_o(ute), .table_selector_o(sel),
        .effective_address_mode_o(ea_mode), .port_protect_o(port_prot),
        .write_protect_o(wr_prot), .deferral_protect_o(def_prot)
    );

    ats_cpu_model ats_cpu_model_i
    (
        .ref_clk_i(ref_clk_i), .read_valid_i(rd_valid), .read_data_i(rd_data),
        .load_op_o(ld), .load_data_o(ld_data), .read_op_o(rd), .event_o(ev),
        .prot_fault_o(flt), .cause_o(cause), .single_cycle_o(sc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input ats_word_t got, input ats_word_t exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rd_word(output ats_word_t w);
        bit ok;
        ats_cpu_model_i.read_word(w, ok);
        if (!ok)
        begin
            fails++;
            print_verdict();
        end
    endtask : rd_word

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd_word(r);
        check(r, 16'h0000);
        check({10'h0, usr_on, dch_on, ea_mode, port_prot, wr_prot, def_prot}, 16'h0000);
        check({14'h0, ute}, 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_pending();
        ats_cpu_model_i.load_word(16'h807b);
        rd_word(r);
        check(r, 16'h0002);
        check({15'h0, dch_on}, 16'h0001);
        check({12'h0, ea_mode, port_prot, wr_prot, def_prot}, 16'h0000);
        ats_cpu_model_i.pulse(0);
        rd_word(r);
        check(r, 16'h807a);
        check({12'h0, ea_mode, port_prot, wr_prot, def_prot}, 16'h000f);
        check({14'h0, ute}, {14'h0, ATS_TABLE_C});
        ats_cpu_model_i.pulse(1);
        ats_cpu_model_i.pulse(0);
        ats_cpu_model_i.idle(1);
        check({15'h0, usr_on}, 16'h0001);
        rd_word(r);
        check(r, 16'hc07a);
        $display("test_pending done");
    endtask : test_pending

    task automatic test_user_tables();
        for (int c = 0; c < 4; c++)
        begin
            ats_cpu_model_i.load_word(16'((c / 2) << 15) | 16'((c % 2) << 2));
            ats_cpu_model_i.pulse(0);
            rd_word(r);
            check(r & 16'h8004, 16'((c / 2) << 15) | 16'((c % 2) << 2));
            check({14'h0, ute}, 16'(c));
            check({15'h0, r[14]}, 16'h0000);
        end
        $display("test_user_tables done");
    endtask : test_user_tables

    task automatic test_fill();
        for (int s = 0; s < 8; s++)
        begin
            ats_cpu_model_i.load_word(16'(s << 7));
            ats_cpu_model_i.pulse(2);
            rd_word(r);
            check({13'h0, r[9:7]}, 16'(s));
            check({13'h0, sel}, 16'(s));
        end
        $display("test_fill done");
    endtask : test_fill

    task automatic test_faults();
        for (int k = 0; k < 3; k++)
        begin
            ats_cpu_model_i.fault(3'(1 << k), k[0]);
            rd_word(r);
            check({12'h0, r[13:10]}, 16'((8 >> k) | (k % 2)));
        end
        $display("test_faults done");
    endtask : test_faults

    task automatic test_interrupt();
        ats_cpu_model_i.load_word(16'h0001);
        ats_cpu_model_i.pulse(1);
        ats_cpu_model_i.pulse(0);
        ats_cpu_model_i.pulse(3);
        rd_word(r);
        check({14'h0, r[14], r[0]}, 16'h0003);
        ats_cpu_model_i.load_word(16'h0000);
        ats_cpu_model_i.pulse(0);
        ats_cpu_model_i.pulse(3);
        rd_word(r);
        check({14'h0, r[14], r[0]}, 16'h0000);
        check({14'h0, r[1], dch_on}, 16'h0000);
        check({12'h0, ea_mode, port_prot, wr_prot, def_prot}, 16'h0000);
        $display("test_interrupt done");
    endtask : test_interrupt

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        fails    = 0;
        n_checks = 0;
        rst_n_i  = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_pending();
        test_user_tables();
        test_fill();
        test_faults();
        test_interrupt();
        print_verdict();
    end

endmodule : tb_top
